/* File: design/cic_pkg.sv */
/*
  constants for the sinc decimator: stage counts, word widths, ratio codes,
  modulator clock division and output buffer depth.
  assumes one synchronous clock domain and no software-visible registers.
*/
package cic_pkg;
  // structure: three integrators, three combs
  localparam int CIC_STAGES = 3;
  // largest comb differential delay supported
  localparam int CIC_DELAY_MAX = 2;
  // largest decimation ratio supported
  localparam int CIC_RATIO_MAX = 256;
  // word width: stages * log2(ratio * delay) + 1
  localparam int CIC_ACC_W = CIC_STAGES * $clog2(CIC_RATIO_MAX * CIC_DELAY_MAX) + 1;
  // sample counter width
  localparam int CIC_CNT_W = $clog2(CIC_RATIO_MAX);
  // ratio select codes
  localparam logic [1:0] CIC_SEL_R64 = 2'h0;
  localparam logic [1:0] CIC_SEL_R128 = 2'h1;
  localparam logic [1:0] CIC_SEL_R256 = 2'h2;
  // ratio values
  localparam logic [CIC_CNT_W:0] CIC_R64 = 9'h040;
  localparam logic [CIC_CNT_W:0] CIC_R128 = 9'h080;
  localparam logic [CIC_CNT_W:0] CIC_R256 = 9'h100;
  // system clock and modulator clock division
  localparam int CIC_CLK_HZ = 25000000;
  localparam int CIC_MOD_CLK_HZ = CIC_CLK_HZ / 2;
  localparam int CIC_MOD_DIV = CIC_CLK_HZ / CIC_MOD_CLK_HZ;
  // output periods before a step has settled
  localparam logic [1:0] CIC_SETTLE_PERIODS = 2'h3;
  // output buffer
  localparam int CIC_FIFO_DEPTH = 32;
  // settle state machine, gray along fill -> run
  typedef enum logic [1:0] {
    CIC_ST_FILL = 2'h0,
    CIC_ST_RUN = 2'h1
  } cic_state_type;
endpackage

/* File: design/cic_sinc_decimator.sv */
/*
  sinc (cic) decimator for a one-bit delta-sigma stream, with its output
  buffer. the block drives the modulator clock, samples the bit stream,
  integrates at the modulator rate, decimates, combs, and queues results.
  assumes the modulator changes its bit on the falling edge of the clock
  it is given and that the reader drains the output through valid/ready.
*/
`timescale 1ns/10ps

module cic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  // handshake terms
  logic push;
  logic pop;
  logic load_out;

  // the output register is refilled when empty or being taken
  assign load_out = (count != '0) && (!out_valid_out || out_ready_in);
  assign push = in_valid_in && in_ready_out;
  assign pop = load_out;

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // full flag as a register: not ready once the last slot is taken
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      in_ready_out <= 1'b1;
    end else begin
      in_ready_out <= (count + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH);
    end
  end

  // registered output stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (load_out) begin
      out_valid_out <= 1'b1;
      out_data_out <= mem[rd_ptr];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule // cic_fifo

module cic_sinc_decimator (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // modulator link
  output logic modulator_clock_output_out,
  input wire logic mod_data_in,
  // configuration levels
  input wire logic [1:0] ratio_sel_in,
  input wire logic comb_delay_two_in,
  // result stream to the reader
  output logic [cic_pkg::CIC_ACC_W-1:0] result_data_out,
  output logic result_valid_out,
  input wire logic result_ready_in,
  // status
  output logic result_strobe_out,
  output logic settled_out,
  output logic overflow_out
);
  // running words
  // word wide enough for precision
  logic [cic_pkg::CIC_ACC_W-1:0] integ [cic_pkg::CIC_STAGES];
  logic [cic_pkg::CIC_ACC_W-1:0] comb_d1 [cic_pkg::CIC_STAGES];
  logic [cic_pkg::CIC_ACC_W-1:0] comb_d2 [cic_pkg::CIC_STAGES];
  logic [cic_pkg::CIC_ACC_W-1:0] comb_val [cic_pkg::CIC_STAGES+1];
  // modulator clock divider and sample timing
  logic mod_clk;
  logic sample_en;
  logic [cic_pkg::CIC_CNT_W:0] samp_cnt;
  logic [cic_pkg::CIC_CNT_W:0] ratio;
  logic decim_en;
  // settle tracking
  cic_pkg::cic_state_type state;
  logic [1:0] settle_cnt;
  // buffer handshake
  logic fifo_ready;
  logic push_valid;
  logic [cic_pkg::CIC_ACC_W-1:0] push_data;

  // bit to +1 / -1
  function automatic logic [cic_pkg::CIC_ACC_W-1:0] bit_to_word(input logic b);
    bit_to_word = b ? cic_pkg::CIC_ACC_W'(1) : '1;
  endfunction

  // ratio select decode
  // codes 2 and 3 both decode to ratio 256
  function automatic logic [cic_pkg::CIC_CNT_W:0] ratio_of(input logic [1:0] sel);
    case (sel)
      cic_pkg::CIC_SEL_R64: ratio_of = cic_pkg::CIC_R64;
      cic_pkg::CIC_SEL_R128: ratio_of = cic_pkg::CIC_R128;
      default: ratio_of = cic_pkg::CIC_R256;
    endcase
  endfunction

  assign ratio = ratio_of(ratio_sel_in);
  // bit taken on the edge that raises the pin, a cycle after its last change
  assign sample_en = mod_clk;
  assign decim_en = sample_en && (samp_cnt == ratio - 1'b1);

  // driven clock, bit sampled in high phase
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mod_clk <= 1'b0;
    end else begin
      mod_clk <= ~mod_clk;
    end
  end

  // pin runs opposite mod_clk, so sampling lands on its rising edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      modulator_clock_output_out <= 1'b0;
    end else begin
      modulator_clock_output_out <= mod_clk;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      samp_cnt <= '0;
    end else if (decim_en || samp_cnt >= ratio) begin
      // wrap, also after a ratio change downward
      samp_cnt <= '0;
    end else if (sample_en) begin
      samp_cnt <= samp_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < cic_pkg::CIC_STAGES; i++) begin
        integ[i] <= '0;
      end
    end else if (sample_en) begin
      integ[0] <= integ[0] + bit_to_word(mod_data_in);
      for (int i = 1; i < cic_pkg::CIC_STAGES; i++) begin
        integ[i] <= integ[i] + integ[i-1];
      end
    end
  end

  always_comb begin
    comb_val[0] = integ[cic_pkg::CIC_STAGES-1];
    for (int i = 0; i < cic_pkg::CIC_STAGES; i++) begin
      if (comb_delay_two_in) begin
        comb_val[i+1] = comb_val[i] - comb_d2[i];
      end else begin
        comb_val[i+1] = comb_val[i] - comb_d1[i];
      end
    end
  end

  // comb delay lines advance at decimated rate
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < cic_pkg::CIC_STAGES; i++) begin
        comb_d1[i] <= '0;
        comb_d2[i] <= '0;
      end
    end else if (decim_en) begin
      for (int i = 0; i < cic_pkg::CIC_STAGES; i++) begin
        comb_d1[i] <= comb_val[i];
        comb_d2[i] <= comb_d1[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      push_data <= '0;
      push_valid <= 1'b0;
      result_strobe_out <= 1'b0;
    end else begin
      push_valid <= decim_en;
      result_strobe_out <= decim_en;
      if (decim_en) begin
        push_data <= comb_val[cic_pkg::CIC_STAGES];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= cic_pkg::CIC_ST_FILL;
      settle_cnt <= '0;
      settled_out <= 1'b0;
    end else begin
      case (state)
        cic_pkg::CIC_ST_FILL: begin
          if (push_valid) begin
            settle_cnt <= settle_cnt + 1'b1;
            if (settle_cnt == cic_pkg::CIC_SETTLE_PERIODS - 1'b1) begin
              state <= cic_pkg::CIC_ST_RUN;
              settled_out <= 1'b1;
            end
          end
        end
        cic_pkg::CIC_ST_RUN: begin
          settled_out <= 1'b1;
        end
        default: begin
          state <= cic_pkg::CIC_ST_FILL;
          settled_out <= 1'b0;
        end
      endcase
    end
  end

  // sticky lost-result flag when the buffer is full
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      overflow_out <= 1'b0;
    end else if (push_valid && !fifo_ready) begin
      overflow_out <= 1'b1;
    end
  end

  // output buffer toward the reader
  cic_fifo #(
    .WIDTH(cic_pkg::CIC_ACC_W),
    .DEPTH(cic_pkg::CIC_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .in_valid_in(push_valid),
    .in_data_in(push_data),
    .in_ready_out(fifo_ready),
    .out_valid_out(result_valid_out),
    .out_data_out(result_data_out),
    .out_ready_in(result_ready_in)
  );
endmodule // cic_sinc_decimator

/* File: test/cic_sinc_decimator_assertions.sv */
/*
  checker for the sinc decimator ports.
  assumes one clock, sync reset, configuration fixed between resets.
*/
`timescale 1ns/10ps
module cic_sinc_decimator_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // watched ports
  input wire logic modulator_clock_output_out,
  input wire logic [1:0] ratio_sel_in,
  input wire logic [cic_pkg::CIC_ACC_W-1:0] result_data_out,
  input wire logic result_valid_out,
  input wire logic result_ready_in,
  input wire logic result_strobe_out,
  input wire logic settled_out,
  input wire logic overflow_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic [9:0] gap; // cycles since last result
  logic seen; // one result already out
  logic [1:0] scnt; // results, saturating
  logic [9:0] span; // expected gap value
  assign span = ratio_sel_in == 2'h0 ? 10'h07F : ratio_sel_in == 2'h1 ? 10'h0FF : 10'h1FF;
  // track result spacing and count
  always_ff @(posedge clk_in) begin
    gap <= (srst_in || result_strobe_out) ? 10'h000 : gap + 10'h001;
    seen <= !srst_in && (seen || result_strobe_out);
    if (srst_in)
      scnt <= 2'h0;
    else if (result_strobe_out && scnt != 2'h3)
      scnt <= scnt + 2'h1;
  end
  // third result after reset
  sequence third_result;
    result_strobe_out && scnt == 2'h2;
  endsequence
  chk_result_spacing: assert property (result_strobe_out && seen |-> gap == span)
    else $error("result spacing wrong");
  chk_mclk_toggle: assert property (!$past(srst_in) && !$past(srst_in, 2)
    |-> modulator_clock_output_out != $past(modulator_clock_output_out))
    else $error("modulator clock stalled");
  chk_settle_time: assert property (third_result |-> ##[0:1] settled_out)
    else $error("settled late");
  chk_settle_early: assert property ($rose(settled_out) |-> scnt >= 2'h2)
    else $error("settled early");
  chk_settled_stays: assert property (settled_out |=> settled_out)
    else $error("settled dropped");
  chk_strobe_pulse: assert property (result_strobe_out |=> !result_strobe_out)
    else $error("strobe too long");
  chk_valid_follows: assert property (result_strobe_out && !result_valid_out |-> ##2 result_valid_out)
    else $error("word not offered");
  chk_word_holds: assert property (result_valid_out && !result_ready_in
    |=> result_valid_out && $stable(result_data_out))
    else $error("word lost before taken");
  chk_overflow_cause: assert property ($rose(overflow_out) |-> $past(result_strobe_out) && result_valid_out)
    else $error("overflow without full buffer");
endmodule // cic_sinc_decimator_chk

bind cic_sinc_decimator cic_sinc_decimator_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
  .modulator_clock_output_out(modulator_clock_output_out), .ratio_sel_in(ratio_sel_in),
  .result_data_out(result_data_out), .result_valid_out(result_valid_out),
  .result_ready_in(result_ready_in), .result_strobe_out(result_strobe_out),
  .settled_out(settled_out), .overflow_out(overflow_out));

/* File: test/cic_mod_model.sv */
/*
  behavioural delta-sigma modulator repeating a four-bit ones pattern.
  assumes the decimator drives its clock; it stands still in reset.
*/
`timescale 1ns/10ps
module cic_mod_model (
  // clock from the decimator
  input wire logic mclk_in,
  // ones pattern, lsb first
  input wire logic [3:0] pattern_in,
  // bit stream
  output logic bit_out
);
  logic [1:0] idx = 2'h0; // pattern position
  initial bit_out = 1'h0;
  always @(negedge mclk_in) begin
    bit_out <= pattern_in[idx];
    idx <= idx + 2'h1;
  end
endmodule // cic_mod_model

/* File: test/tb_cic_sinc_decimator.sv */
/*
  testbench for the sinc decimator: random patterns for each ratio and delay,
  settled words, buffer overflow and drain.
  assumes the modulator model and the bound checker compile alongside.
*/
`timescale 1ns/10ps
module tb_cic_sinc_decimator;
  logic clk_in; // system clock
  logic srst_in; // sync reset
  logic mclk, mbit; // modulator link
  logic [1:0] sel; // ratio select
  logic m2; // comb delay two
  logic [cic_pkg::CIC_ACC_W-1:0] data, w; // result word, captured word
  logic valid, ready, strobe, settled, ovf; // result side
  logic [3:0] pat; // modulator pattern
  int fail_count, compares, n;
  int pq[$]; // pattern as +1/-1
  cic_sinc_decimator dut (.clk_in(clk_in), .srst_in(srst_in),
    .modulator_clock_output_out(mclk), .mod_data_in(mbit), .ratio_sel_in(sel),
    .comb_delay_two_in(m2), .result_data_out(data), .result_valid_out(valid),
    .result_ready_in(ready), .result_strobe_out(strobe), .settled_out(settled),
    .overflow_out(ovf));
  cic_mod_model modu (.mclk_in(mclk), .pattern_in(pat), .bit_out(mbit));
  // 40 ns clock
  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  // compare and count
  task automatic check(string name, logic [cic_pkg::CIC_ACC_W-1:0] seen, want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask
  // verdict and stop
  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // settled word: (R*M)^3 times the stream mean, wrapping
  function automatic logic [cic_pkg::CIC_ACC_W-1:0] expect_word();
    int rm, s;
    rm = (sel == 2'h0 ? 64 : sel == 2'h1 ? 128 : 256) * (m2 ? 2 : 1);
    s = 0;
    foreach (pq[i]) s += pq[i];
    return cic_pkg::CIC_ACC_W'(rm * rm * rm / pq.size() * s);
  endfunction
  // configure, new random pattern, reset six cycles
  task automatic start(logic [1:0] s, logic d, logic r);
    @(posedge clk_in);
    sel <= s;
    m2 <= d;
    ready <= r;
    pat <= 4'($urandom_range(14, 1));
    srst_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    srst_in <= 1'h0;
    pq = {};
    for (int i = 0; i < 4; i++) pq.push_back(pat[i] ? 1 : -1);
  endtask
  // next word taken by the reader, bounded wait
  task automatic take(output logic [cic_pkg::CIC_ACC_W-1:0] v);
    int k;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (!(valid === 1'h1 && ready === 1'h1) && k < 1200);
    v = data;
    if (k >= 1200) fail_count++;
    @(posedge clk_in);
  endtask
  // watchdog
  initial begin
    #(80000 * 40);
    fail_count++;
    end_sim();
  end
  initial begin
    srst_in = 1'h1;
    sel = 2'h0;
    m2 = 1'h0;
    ready = 1'h0;
    pat = 4'h0;
    fail_count = 0;
    compares = 0;
    void'($urandom(19));
    // every ratio code, delays 1 and 2
    for (int c = 0; c < 8; c++) begin
      start(2'(c >> 1), c[0], 1'h1);
      for (int j = 0; j < 9; j++) begin
        take(w);
        check("settle", settled, 28'(j > 1));
        if (j >= 7) check("word", w, expect_word());
      end
      check("settled", settled, 1'h1);
    end
    // full buffer drops, then drains whole
    start(2'h0, 1'h0, 1'h0);
    repeat (41 * 128) @(negedge clk_in);
    check("overflow", ovf, 1'h1);
    n = 0;
    while (strobe !== 1'h1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    ready <= 1'h1;
    n = 0;
    @(negedge clk_in);
    while (valid === 1'h1 && n < 40) begin
      n++;
      if (n > 8) check("drained", data, expect_word());
      @(negedge clk_in);
    end
    check("count", 28'(n), 28'h21);
    end_sim();
  end
endmodule // tb_cic_sinc_decimator
